// ### core/sfc_defines.svh
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH

// opcodes
`define SFC_OP_PAGE_READ   8'h52
`define SFC_OP_BUF1_READ   8'h54
`define SFC_OP_BUF2_READ   8'h56
`define SFC_OP_XFER1       8'h53
`define SFC_OP_XFER2       8'h55
`define SFC_OP_CMP1        8'h60
`define SFC_OP_CMP2        8'h61
`define SFC_OP_BUF1_WRITE  8'h84
`define SFC_OP_BUF2_WRITE  8'h87

// address field layout, 24 bits after the opcode
`define SFC_ADDR_BYTES     2'h3
`define SFC_RSV_MSB        23
`define SFC_RSV_LSB        22
`define SFC_PAGE_MSB       21
`define SFC_PAGE_LSB       10
`define SFC_OFS_MSB        9
`define SFC_OFS_LSB        0

// don't-care bytes ahead of read data
`define SFC_DUMMY_PAGE_RD  2'h3
`define SFC_DUMMY_BUF_RD   2'h0

// framing, reset, fill and fifo depth values
`define SFC_BIT_LAST       3'h7
`define SFC_MODE_RESET     1'b1
`define SFC_IDLE_FILL      8'hff
`define SFC_FIFO_DEPTH     16

`endif

// ### core/sfc_pkg.sv
package sfc_pkg;

  typedef enum logic [3:0] {
    OP_NONE     = 4'b0000,
    OP_PAGE_RD  = 4'b0001,
    OP_BUF1_RD  = 4'b0010,
    OP_BUF2_RD  = 4'b0011,
    OP_XFER1    = 4'b0100,
    OP_XFER2    = 4'b0101,
    OP_CMP1     = 4'b0110,
    OP_CMP2     = 4'b0111,
    OP_BUF1_WR  = 4'b1000,
    OP_BUF2_WR  = 4'b1001
  } sfc_op_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPC    = 3'b001,
    ST_ADDR   = 3'b010,
    ST_DUMMY  = 3'b011,
    ST_DATA   = 3'b100,
    ST_IGNORE = 3'b101
  } sfc_state_t;

  typedef struct packed {
    sfc_op_t     op;
    logic [11:0] flash_row_index;
    logic [9:0]  buffer_byte_offset;
  } sfc_cmd_t;

endpackage

// ### core/sfc_port.sv
`include "sfc_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module sfc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  assign in_ready  = cnt_q != (AW+1)'(D);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem[rd_q];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + AW'(1);
      if (pop) rd_q <= rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sfc_port (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // serial pins
  input  wire logic              cs_n,
  input  wire logic              sck,
  input  wire logic              si,
  output logic                   so_o,
  output logic                   so_oe_n,
  output logic                   rdy_busy_n_o,
  output logic                   rdy_busy_n_oe_n,
  // decoded command
  output sfc_pkg::sfc_cmd_t      cmd,
  output logic                   cmd_valid,
  output logic                   mode3,
  // self-timed operation finished
  input  wire logic              op_done,
  // read data source
  input  wire logic [7:0]        rd_data,
  input  wire logic              rd_valid,
  output logic                   rd_ready,
  // write data sink
  output logic [7:0]             wr_data,
  output logic                   wr_valid,
  input  wire logic              wr_ready,
  output logic                   wr_overrun
);

  function automatic sfc_pkg::sfc_op_t decode(input logic [7:0] b);
    unique case (b)
      `SFC_OP_PAGE_READ:  decode = sfc_pkg::OP_PAGE_RD;
      `SFC_OP_BUF1_READ:  decode = sfc_pkg::OP_BUF1_RD;
      `SFC_OP_BUF2_READ:  decode = sfc_pkg::OP_BUF2_RD;
      `SFC_OP_XFER1:      decode = sfc_pkg::OP_XFER1;
      `SFC_OP_XFER2:      decode = sfc_pkg::OP_XFER2;
      `SFC_OP_CMP1:       decode = sfc_pkg::OP_CMP1;
      `SFC_OP_CMP2:       decode = sfc_pkg::OP_CMP2;
      `SFC_OP_BUF1_WRITE: decode = sfc_pkg::OP_BUF1_WR;
      `SFC_OP_BUF2_WRITE: decode = sfc_pkg::OP_BUF2_WR;
      default:            decode = sfc_pkg::OP_NONE;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, a change counts once stages two and three agree
  logic [2:0] cs_s_q, sck_s_q, si_s_q;
  logic       cs_f_q, sck_f_q, si_f_q;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cs_s_q  <= 3'h7;
      sck_s_q <= 3'h7;
      si_s_q  <= 3'h0;
      cs_f_q  <= 1'b1;
      sck_f_q <= 1'b1;
      si_f_q  <= 1'b0;
    end else begin
      cs_s_q  <= {cs_s_q[1:0], cs_n};
      sck_s_q <= {sck_s_q[1:0], sck};
      si_s_q  <= {si_s_q[1:0], si};
      if (cs_s_q[1] == cs_s_q[2]) cs_f_q <= cs_s_q[2];
      if (sck_s_q[1] == sck_s_q[2]) sck_f_q <= sck_s_q[2];
      if (si_s_q[1] == si_s_q[2]) si_f_q <= si_s_q[2];
    end
  end

  wire sck_now  = (sck_s_q[1] == sck_s_q[2]) ? sck_s_q[2] : sck_f_q;
  wire cs_now   = (cs_s_q[1] == cs_s_q[2]) ? cs_s_q[2] : cs_f_q;
  wire cs_fall  = cs_f_q && !cs_now;
  wire cs_rise  = !cs_f_q && cs_now;
  wire selected = !cs_f_q && !cs_now;
  wire sck_rise = selected && !sck_f_q && sck_now;
  wire sck_fall = selected && sck_f_q && !sck_now;

  //////////////////////////////////////////////////////////////////////////////
  // command framing
  sfc_pkg::sfc_state_t state_q, state_d;
  sfc_pkg::sfc_op_t    op_q;
  logic [7:0]          sh_q;
  logic [2:0]          bit_q;
  logic [1:0]          byte_q;
  logic [23:0]         addr_q;
  sfc_pkg::sfc_cmd_t   cmd_q;
  logic                mode_q, busy_q, pend_q, cmdv_q, ovr_q;

  wire [7:0] sh_next    = {sh_q[6:0], si_f_q};
  wire       byte_done  = sck_rise && (bit_q == `SFC_BIT_LAST);
  wire [7:0] last_byte  = byte_done ? sh_next : 8'h00;
  wire       addr_done  = byte_done && byte_q == `SFC_ADDR_BYTES - 2'h1;
  wire       is_page_rd = op_q == sfc_pkg::OP_PAGE_RD;
  wire       is_buf_rd  = op_q == sfc_pkg::OP_BUF1_RD || op_q == sfc_pkg::OP_BUF2_RD;
  wire       is_read    = is_page_rd || is_buf_rd;
  wire       is_write   = op_q == sfc_pkg::OP_BUF1_WR || op_q == sfc_pkg::OP_BUF2_WR;
  wire [1:0] dummy_n    = is_page_rd ? `SFC_DUMMY_PAGE_RD : `SFC_DUMMY_BUF_RD;
  wire       selftimed  = !is_read && !is_write;
  wire [23:0] addr_next = {addr_q[15:0], sh_next};

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sfc_pkg::ST_IDLE:   if (cs_fall) state_d = sfc_pkg::ST_OPC;
      sfc_pkg::ST_OPC:    if (byte_done) state_d = (decode(last_byte) == sfc_pkg::OP_NONE) ?
                                                   sfc_pkg::ST_IGNORE : sfc_pkg::ST_ADDR;
      sfc_pkg::ST_ADDR:   if (addr_done) begin
        if (is_read && dummy_n != 2'h0) state_d = sfc_pkg::ST_DUMMY;
        else if (selftimed) state_d = sfc_pkg::ST_IGNORE;
        else state_d = sfc_pkg::ST_DATA;
      end
      sfc_pkg::ST_DUMMY:  if (byte_done && byte_q == dummy_n - 2'h1) state_d = sfc_pkg::ST_DATA;
      sfc_pkg::ST_DATA, sfc_pkg::ST_IGNORE: state_d = state_q;
      default:            state_d = sfc_pkg::ST_IDLE;
    endcase
    if (cs_rise) state_d = sfc_pkg::ST_IDLE;
  end

  wire byte_wrap = (state_q != state_d) || (state_q == sfc_pkg::ST_DATA);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q <= sfc_pkg::ST_IDLE;
      op_q    <= sfc_pkg::OP_NONE;
      sh_q    <= 8'h00;
      bit_q   <= 3'h0;
      byte_q  <= 2'h0;
      addr_q  <= 24'h000000;
      mode_q  <= `SFC_MODE_RESET;
      cmdv_q  <= 1'b0;
      cmd_q   <= '0;
    end else begin
      state_q <= state_d;
      cmdv_q  <= (state_q == sfc_pkg::ST_ADDR) && addr_done;
      if (state_q == sfc_pkg::ST_ADDR && addr_done) cmd_q <= {op_q, addr_next[`SFC_PAGE_MSB:`SFC_OFS_LSB]};
      if (cs_fall) begin
        mode_q <= sck_f_q;
        bit_q  <= 3'h0;
        byte_q <= 2'h0;
      end else if (sck_rise) begin
        sh_q  <= sh_next;
        bit_q <= bit_q + 3'h1;
        if (byte_done) byte_q <= byte_wrap ? 2'h0 : byte_q + 2'h1;
      end
      if (state_q == sfc_pkg::ST_OPC && byte_done) op_q <= decode(last_byte);
      if (state_q == sfc_pkg::ST_ADDR && byte_done) addr_q <= addr_next;
    end
  end

  assign cmd                    = cmd_q;
  assign cmd_valid              = cmdv_q;
  assign mode3                  = mode_q;

  //////////////////////////////////////////////////////////////////////////////
  // busy flag, set at select rise after a self-timed command
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pend_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      if (state_q == sfc_pkg::ST_ADDR && addr_done && selftimed) pend_q <= 1'b1;
      else if (cs_rise) pend_q <= 1'b0;
      if (cs_rise && pend_q) busy_q <= 1'b1;
      else if (op_done) busy_q <= 1'b0;
    end
  end

  assign rdy_busy_n_o    = 1'b0;
  assign rdy_busy_n_oe_n = !busy_q;

  //////////////////////////////////////////////////////////////////////////////
  // read data out, changes on the falling serial clock edge
  logic [6:0] tx_q;
  logic [2:0] tx_bit_q;
  logic       so_q, drive_q;
  wire        rd_phase = state_q == sfc_pkg::ST_DATA && is_read;
  wire        rd_load  = rd_phase && sck_fall && tx_bit_q == 3'h0;
  wire [7:0]  rd_byte  = rd_valid ? rd_data : `SFC_IDLE_FILL;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tx_q     <= 7'h00;
      tx_bit_q <= 3'h0;
      so_q     <= 1'b0;
      drive_q  <= 1'b0;
    end else begin
      if (!rd_phase) begin
        tx_bit_q <= 3'h0;
        drive_q  <= 1'b0;
      end else if (sck_fall) begin
        drive_q  <= 1'b1;
        tx_bit_q <= tx_bit_q + 3'h1;
        if (rd_load) begin
          so_q <= rd_byte[7];
          tx_q <= rd_byte[6:0];
        end else begin
          so_q <= tx_q[6];
          tx_q <= {tx_q[5:0], 1'b0};
        end
      end
    end
  end

  assign rd_ready = rd_load;
  assign so_o     = so_q;
  assign so_oe_n  = !(drive_q && rd_phase);

  //////////////////////////////////////////////////////////////////////////////
  // write data into the fifo
  logic       fifo_in_ready;
  wire        wr_push = state_q == sfc_pkg::ST_DATA && is_write && byte_done;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ovr_q <= 1'b0;
    end else if (wr_push && !fifo_in_ready) begin
      ovr_q <= 1'b1;
    end else if (cs_fall) begin
      ovr_q <= 1'b0;
    end
  end

  assign wr_overrun = ovr_q;

  sfc_fifo #(
    .W (8),
    .D (`SFC_FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_data   (sh_next),
    .in_valid  (wr_push),
    .in_ready  (fifo_in_ready),
    .out_data  (wr_data),
    .out_valid (wr_valid),
    .out_ready (wr_ready)
  );
endmodule

// ### test/sfc_host_model.sv
module sfc_host_model (
  // serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so_o,
  input  wire logic so_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cs_n = 1'b1;
    sck  = 1'b1;
    si   = 1'b0;
  end
  // whole bytes, clock still outside frames
  task automatic frame(input bit m3, input logic [7:0] tx[$], input int nrx, output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    sck = m3;
    #250 cs_n = 1'b0;
    #250;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        sck = 1'b0;
        si = tx[i][k];
        #100 sck = 1'b1;
        #99 b[k] = so_oe_n ? 1'bx : so_o;
        #1;
      end
      if (i >= tx.size() - nrx) rx.push_back(b);
    end
    if (!m3) sck = 1'b0;
    #250 cs_n = 1'b1;
    si = ~si;
  endtask
endmodule

// ### test/sfc_port_bench.sv
module sfc_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic              mclk, rstn, cs_n, sck, si, so_o, so_oe_n, rdy_o, rdy_oe_n;
  logic              cmd_valid, mode3, op_done, rd_ready, wr_valid, wr_ready, wr_overrun, stall;
  logic [7:0]        rd_data, wr_data, b;
  sfc_pkg::sfc_cmd_t cmd;
  sfc_pkg::sfc_cmd_t cmd_q[$];
  logic [7:0]        wr_q[$], rd_q[$], tx[$], rx[$];
  int                fail_count, samples_checked, cycles;
  localparam logic [7:0] OPC [10] = '{8'h00, 8'h52, 8'h54, 8'h56, 8'h53, 8'h55, 8'h60, 8'h61, 8'h84, 8'h87};

  sfc_port DUT (.mclk(mclk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si), .so_o(so_o), .so_oe_n(so_oe_n),
    .rdy_busy_n_o(rdy_o), .rdy_busy_n_oe_n(rdy_oe_n), .cmd(cmd), .cmd_valid(cmd_valid), .mode3(mode3),
    .op_done(op_done), .rd_data(rd_data), .rd_valid(1'b1), .rd_ready(rd_ready), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_overrun(wr_overrun));
  sfc_host_model host (.cs_n(cs_n), .sck(sck), .si(si), .so_o(so_o), .so_oe_n(so_oe_n));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [25:0] got, input logic [25:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // page bits of buffer ops and offset of transfers are don't-care
  task automatic cmp_cmd(input sfc_pkg::sfc_cmd_t got, input sfc_pkg::sfc_cmd_t exp);
    if (exp.op inside {[2:3], [8:9]}) begin
      got.flash_row_index = '0;
      exp.flash_row_index = '0;
    end
    if (exp.op inside {[4:7]}) begin
      got.buffer_byte_offset = '0;
      exp.buffer_byte_offset = '0;
    end
    cmp(got, exp);
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic drain();
    for (int k = 0; k < 400 && wr_q.size() > 0; k++) @(posedge mclk);
    #2 cmp(wr_q.size(), 0);
  endtask
  task automatic run(input int i, input bit m3, input int n);
    logic [23:0] a;
    bit          rd;
    a = {2'b00, 22'($urandom)};
    rd = i inside {[1:3]};
    tx = {OPC[i], a[23:16], a[15:8], a[7:0]};
    if (i > 0) cmd_q.push_back({sfc_pkg::sfc_op_t'(i), a[21:0]});
    if (i == 1) repeat (3) tx.push_back(8'hc3);
    for (int k = 0; k < n; k++) begin
      b = 8'($urandom);
      tx.push_back(b);
      if (i > 7 && wr_q.size() < 16) wr_q.push_back(b);
    end
    rd_q = {};
    host.frame(m3, tx, rd ? n : 0, rx);
    cmp(rd ? rd_q.size() >= n : 1'b1, 1'b1);
    foreach (rx[k]) cmp(rx[k], rd_q[k]);
    cmp(mode3, m3);
    if (i inside {[4:7]}) begin
      repeat (9) @(posedge mclk);
      #2 cmp(rdy_oe_n, 1'b0);
      op_done = 1'b1;
      @(posedge mclk);
      #2 op_done = 1'b0;
      @(posedge mclk);
      #2 cmp(rdy_oe_n, 1'b1);
    end
    $display("test done: opcode %h mode3 %0d", OPC[i], m3);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge mclk) begin
    if (rstn && cmd_valid) cmp_cmd(cmd, cmd_q.size() ? cmd_q.pop_front() : '0);
    if (rstn && wr_valid && wr_ready) cmp(wr_data, wr_q.size() ? wr_q.pop_front() : 8'hxx);
    if (rd_ready) rd_q.push_back(rd_data);
  end
  always @(posedge mclk) begin
    #2 wr_ready = !stall && 1'($urandom);
    rd_data = 8'($urandom);
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    rstn = 1'b0;
    op_done = 1'b0;
    stall = 1'b0;
    rd_data = 8'h00;
    wr_ready = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    void'($urandom(95800));
    repeat (3) @(posedge mclk);
    #2 rstn = 1'b1;
    repeat (4) @(posedge mclk);
    #2 cmp(so_oe_n, 1'b1);
    cmp(mode3, 1'b1);
    for (int i = 0; i < 20; i++) run(i % 10, i / 10, 2 + i % 2);
    drain();
    stall = 1'b1;
    run(8, 1'b0, 20);
    cmp(wr_overrun, 1'b1);
    stall = 1'b0;
    drain();
    run(9, 1'b1, 1);
    cmp(wr_overrun, 1'b0);
    drain();
    cmp(cmd_q.size(), 0);
    wrap_up();
  end
endmodule

// ### test/sfc_port_sva.sv
module sfc_port_sva (
  // clock and reset
  input wire logic              mclk,
  input wire logic              rstn,
  // serial pins
  input wire logic              cs_n,
  input wire logic              sck,
  input wire logic              so_oe_n,
  input wire logic              rdy_busy_n_o,
  input wire logic              rdy_busy_n_oe_n,
  // command and data
  input wire sfc_pkg::sfc_cmd_t cmd,
  input wire logic              cmd_valid,
  input wire logic              mode3,
  input wire logic              op_done,
  input wire logic              rd_ready,
  input wire logic [7:0]        wr_data,
  input wire logic              wr_valid,
  input wire logic              wr_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence cs_idle;
    cs_n [*6];
  endsequence
  sequence busy_gone;
    ##1 rdy_busy_n_oe_n;
  endsequence
  reset_state_a: assert property (disable iff (1'b0) !rstn |=> so_oe_n && rdy_busy_n_oe_n && mode3 && !cmd_valid)
    else $error("outputs not at reset state");
  od_low_a: assert property (rdy_busy_n_o == 1'b0)
    else $error("ready/busy drives high");
  mode_pick_a: assert property ($changed(mode3) |-> mode3 == sck && !cs_n)
    else $error("mode not taken from idle clock");
  cmd_pulse_a: assert property (cmd_valid |-> !cs_n && cmd.op != sfc_pkg::OP_NONE ##1 !cmd_valid)
    else $error("bad command pulse");
  cmd_hold_a: assert property ($changed(cmd) |-> cmd_valid)
    else $error("command changed without pulse");
  so_float_a: assert property (cs_idle |-> so_oe_n)
    else $error("serial output driven while deselected");
  wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("write head dropped while stalled");
  busy_clear_a: assert property (op_done && cs_n && $past(cs_n, 5) |-> busy_gone)
    else $error("busy not cleared by done");
  busy_start_a: assert property ($fell(rdy_busy_n_oe_n) |-> cs_n)
    else $error("busy while selected");
  rd_take_a: assert property (rd_ready |-> !cs_n ##1 !rd_ready)
    else $error("read byte taken outside frame");
endmodule

bind sfc_port sfc_port_sva u_sva (.mclk(mclk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .so_oe_n(so_oe_n),
  .rdy_busy_n_o(rdy_busy_n_o), .rdy_busy_n_oe_n(rdy_busy_n_oe_n), .cmd(cmd), .cmd_valid(cmd_valid),
  .mode3(mode3), .op_done(op_done), .rd_ready(rd_ready), .wr_data(wr_data), .wr_valid(wr_valid),
  .wr_ready(wr_ready));
